// *** core/sewp_core.v ***
// Function
// - Status-write command selects one of four array protection levels
// - Code 00 none, 01 locks 1800h-1FFFh, 10 1000h-1FFFh, 11 all
// - Hardware-protect enable is a nonvolatile status bit gating the protect pin
// - Hardware protection active when pin low and enable bit one
// - Hardware protection inactive when pin high or enable bit zero
// - Hardware protection blocks only status nonvolatile bits, not unprotected array
// - Write latch cleared at power-up
// - Write latch cleared after each completed write
// - Write starts only if select rises after exact bit count
// - Array accesses ignored during an internal write cycle
// - After power-up device idles as if deselected
// - Serial output high-impedance after power-up
// - Only a falling select edge after power-up activates the device
// - Status-write opcode 01h, latch-set 06h, sent MSB first
// - Status bits: enable 7, protect 3 and 2, latch 1, busy 0
// - Latch set and clear always work; latch flag not written by status-write
// Purpose: Write-protect and power-on control of an SPI serial EEPROM
// Assumes: SPI mode 0, link pins sampled by clock_i
// Notes:   Array storage itself lies outside; array_wr_o requests a program
`timescale 1ns/100ps
`include "sewp_regs.vh"
module sewp_core #(
  parameter CLK_PERIOD_NS = 10,
  parameter WRITE_CYCLES  = `SEWP_WRITE_TIME_NS / CLK_PERIOD_NS
) (
  input  wire        clock_i,
  input  wire        rst_i,
  input  wire        sel_n_i,
  input  wire        sck_i,
  input  wire        sdi_i,
  input  wire        wp_n_i,
  output reg         sdo_o,
  output wire        sdo_oe_o,
  output reg         array_wr_o,
  output reg  [12:0] array_addr_o,
  output reg  [7:0]  array_data_o,
  output wire [7:0]  status_o,
  output wire        hw_protect_o
);
  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  wire [3:0] pins_s;
  // Select, clock and data start low, protect pin starts high
  sewp_sync #(
    .W       (4),
    .RST_VAL (4'h1)
  ) u_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .async_i ({sel_n_i, sck_i, sdi_i, wp_n_i}),
    .sync_o  (pins_s)
  );
  wire sel_n_s = pins_s[3];
  wire sck_s   = pins_s[2];
  wire sdi_s   = pins_s[1];
  wire wp_n_s  = pins_s[0];
  reg  sck_q;
  reg  sel_n_q;
  wire sck_rise = sck_s & ~sck_q;
  wire sck_fall = ~sck_s & sck_q;
  wire sel_fall = ~sel_n_s & sel_n_q;
  wire sel_rise = sel_n_s & ~sel_n_q;

  // ************************************************************
  // Status state
  // ************************************************************
  reg        hw_protect_enable_bit;
  reg        block_protect_hi;
  reg        block_protect_lo;
  reg        write_latch_flag;
  reg        write_busy_flag;
  reg        active_q;
  reg [5:0]  bits_q;
  reg [7:0]  opc_q;
  reg [7:0]  shift_q;
  reg [12:0] addr_q;
  reg [7:0]  data_q;
  reg [7:0]  tx_q;
  reg        byte_ok_q;
  reg [31:0] busy_cnt_q;
  reg        oe_q;
  localparam [2:0] NV_RESET = `SEWP_NV_RESET;
  wire [7:0] status_byte = {hw_protect_enable_bit, 3'h0, block_protect_hi,
                            block_protect_lo, write_latch_flag, write_busy_flag};
  assign status_o = status_byte;
  assign hw_protect_o = ~wp_n_s & hw_protect_enable_bit;
  assign sdo_oe_o = oe_q;
  wire [1:0] bp = {block_protect_hi, block_protect_lo};
  wire [12:0] wr_addr = addr_q;
  // Pointer runs one byte ahead; the byte to program sits one below it
  wire [12:0] prog_addr = {addr_q[12:5], addr_q[4:0] - 5'h01};
  reg  addr_locked;
  always @* begin
    case (bp)
      `SEWP_BP_NONE:    addr_locked = 1'b0;
      `SEWP_BP_QUARTER: addr_locked = (prog_addr >= `SEWP_ADDR_QUARTER);
      `SEWP_BP_HALF:    addr_locked = (prog_addr >= `SEWP_ADDR_HALF);
      default:          addr_locked = 1'b1;
    endcase
  end
  wire [5:0]  bits_nx  = bits_q + 6'h01;
  wire [7:0]  shift_nx = {shift_q[6:0], sdi_s};
  wire        data_phase = (opc_q == `SEWP_OP_ARRAY_WRITE) && (bits_q >= `SEWP_ADDR_END);
  wire        byte_done  = (bits_nx[2:0] == 3'h0);

  // ************************************************************
  // Frame decode and write control
  // ************************************************************
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sck_q <= 1'b0;
      // Low so that a select already low at power-up shows no edge
      sel_n_q <= 1'b0;
      active_q <= 1'b0;
      hw_protect_enable_bit <= NV_RESET[2];
      block_protect_hi <= NV_RESET[1];
      block_protect_lo <= NV_RESET[0];
      write_latch_flag <= 1'b0;
      write_busy_flag <= 1'b0;
      bits_q <= 6'h00;
      opc_q <= 8'h00;
      shift_q <= 8'h00;
      addr_q <= 13'h0000;
      data_q <= 8'h00;
      tx_q <= 8'h00;
      byte_ok_q <= 1'b0;
      busy_cnt_q <= 32'h0000_0000;
      oe_q <= 1'b0;
      sdo_o <= 1'b0;
      array_wr_o <= 1'b0;
      array_addr_o <= 13'h0000;
      array_data_o <= 8'h00;
    end else begin
      sck_q <= sck_s;
      sel_n_q <= sel_n_s;
      array_wr_o <= 1'b0;
      if (write_busy_flag) begin
        if (busy_cnt_q == 32'h0000_0000) begin
          write_busy_flag <= 1'b0;
        end else begin
          busy_cnt_q <= busy_cnt_q - 32'h0000_0001;
        end
      end
      if (sel_fall) begin
        active_q <= 1'b1;
        bits_q <= 6'h00;
        byte_ok_q <= 1'b0;
      end else if (sel_n_s) begin
        active_q <= 1'b0;
        oe_q <= 1'b0;
      end
      if (active_q && !sel_n_s && sck_rise) begin
        shift_q <= shift_nx;
        if (data_phase && bits_q == `SEWP_BYTE1_LAST) begin
          // Later page bytes reuse the second data byte's count window
          bits_q <= `SEWP_BYTE1_END;
        end else if (bits_q != 6'h3f) begin
          bits_q <= bits_nx;
        end
        if (bits_nx == `SEWP_OPC_BITS) begin
          opc_q <= shift_nx;
          if (shift_nx == `SEWP_OP_STATUS_READ) begin
            tx_q <= status_byte;
          end
        end else if (opc_q == `SEWP_OP_ARRAY_WRITE && bits_nx == `SEWP_ADDR_HI_END) begin
          addr_q[12:8] <= shift_nx[4:0];
        end else if (opc_q == `SEWP_OP_ARRAY_WRITE && bits_nx == `SEWP_ADDR_END) begin
          addr_q[7:0] <= shift_nx;
        end
        if (data_phase && byte_done) begin
          data_q <= shift_nx;
          byte_ok_q <= 1'b1;
          if (bits_q > `SEWP_ADDR_END) begin
            addr_q <= {wr_addr[12:5], wr_addr[4:0] + 5'h01};
          end
        end else if (opc_q == `SEWP_OP_STATUS_WRITE && bits_nx == `SEWP_SWR_BITS) begin
          data_q <= shift_nx;
        end
      end
      if (active_q && !sel_n_s && sck_fall && opc_q == `SEWP_OP_STATUS_READ
          && bits_q >= `SEWP_OPC_BITS) begin
        oe_q <= 1'b1;
        sdo_o <= tx_q[7];
        tx_q <= {tx_q[6:0], tx_q[7]};
      end
      if (active_q && sel_rise && bits_q[2:0] == 3'h0) begin
        if (bits_q == `SEWP_OPC_BITS && opc_q == `SEWP_OP_LATCH_SET) begin
          write_latch_flag <= 1'b1;
        end else if (bits_q == `SEWP_OPC_BITS && opc_q == `SEWP_OP_LATCH_CLEAR) begin
          write_latch_flag <= 1'b0;
        end else if (!write_busy_flag && write_latch_flag) begin
          if (opc_q == `SEWP_OP_STATUS_WRITE && bits_q == `SEWP_SWR_BITS) begin
            if (!hw_protect_o) begin
              hw_protect_enable_bit <= data_q[`SEWP_BIT_HPE];
              block_protect_hi <= data_q[`SEWP_BIT_BPH];
              block_protect_lo <= data_q[`SEWP_BIT_BPL];
              write_latch_flag <= 1'b0;
              write_busy_flag <= 1'b1;
              busy_cnt_q <= WRITE_CYCLES;
            end
          end else if (opc_q == `SEWP_OP_ARRAY_WRITE && byte_ok_q
                       && bits_q > `SEWP_ADDR_END) begin
            if (!addr_locked) begin
              array_wr_o <= 1'b1;
              array_addr_o <= prog_addr;
              array_data_o <= data_q;
              write_latch_flag <= 1'b0;
              write_busy_flag <= 1'b1;
              busy_cnt_q <= WRITE_CYCLES;
            end
          end
        end
      end
    end
  end
endmodule

// *** common/sewp_regs.vh ***
// Purpose: Constants for the serial EEPROM write-protect block
// Assumes: Status byte layout and opcodes as used by the host
// Notes:   Definitions only
`ifndef SEWP_REGS_VH
`define SEWP_REGS_VH
`define SEWP_OP_STATUS_WRITE 8'h01
`define SEWP_OP_LATCH_SET    8'h06
`define SEWP_OP_LATCH_CLEAR  8'h04
`define SEWP_OP_STATUS_READ  8'h05
`define SEWP_OP_ARRAY_WRITE  8'h02
`define SEWP_OP_ARRAY_READ   8'h03
`define SEWP_BIT_HPE         7
`define SEWP_BIT_BPH         3
`define SEWP_BIT_BPL         2
`define SEWP_BIT_WLF         1
`define SEWP_BIT_BUSY        0
`define SEWP_BP_NONE         2'h0
`define SEWP_BP_QUARTER      2'h1
`define SEWP_BP_HALF         2'h2
`define SEWP_ADDR_QUARTER    13'h1800
`define SEWP_ADDR_HALF       13'h1000
`define SEWP_NV_RESET        3'h0
`define SEWP_OPC_BITS        6'h08
`define SEWP_ADDR_HI_END     6'h10
`define SEWP_ADDR_END        6'h18
`define SEWP_BYTE1_END       6'h20
`define SEWP_BYTE1_LAST      6'h27
`define SEWP_SWR_BITS        6'h10
`define SEWP_WRITE_TIME_NS   5000000
`endif

// *** core/sewp_sync.v ***
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to clock_i
// Notes:   First stage feeds only the second
`timescale 1ns/100ps
module sewp_sync #(
  parameter         W       = 4,
  parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
  input  wire         clock_i,
  input  wire         rst_i,
  input  wire [W-1:0] async_i,
  output reg  [W-1:0] sync_o
);
  reg [W-1:0] meta_q;
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule

// *** test/sewp_monitor.sv ***
// Purpose: Checker for sewp_core ports
// Assumes: WRITE_CYCLES of at least 7
// Notes:   Bound to every sewp_core
`timescale 1ns/100ps
module sewp_monitor (
  input logic        clock_i,
  input logic        rst_i,
  input logic        sel_n_i,
  input logic        wp_n_i,
  input logic        sdo_oe_o,
  input logic        array_wr_o,
  input logic [12:0] array_addr_o,
  input logic [7:0]  status_o,
  input logic        hw_protect_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  hw_prot_a: assert property (hw_protect_o == (!$past(wp_n_i, 2) && status_o[7]))
    else $error("hw protect wrong");
  idle_quiet_a: assert property (sel_n_i [*4] |-> !sdo_oe_o)
    else $error("sdo driven while idle");
  wr_latch_a: assert property (array_wr_o |-> $past(status_o[1]))
    else $error("write without latch");
  wr_clear_a: assert property (array_wr_o |-> !status_o[1] && status_o[0])
    else $error("latch not cleared");
  wr_map_a: assert property (array_wr_o |-> !(&$past(status_o[3:2]))
    && !($past(status_o[3]) && array_addr_o[12])
    && !($past(status_o[2]) && &array_addr_o[12:11]))
    else $error("locked address written");
  busy_hold_a: assert property ($rose(status_o[0]) |-> status_o[0] [*8])
    else $error("busy too short");
  busy_no_wr_a: assert property ($past(status_o[0]) |-> !array_wr_o)
    else $error("write while busy");
  sr_locked_a: assert property ($past(hw_protect_o) |-> $stable({status_o[7], status_o[3:2]}))
    else $error("status changed while locked");
  spare_zero_a: assert property (status_o[6:4] == 3'h0)
    else $error("spare status bits set");
endmodule
bind sewp_core sewp_monitor mon (
  .clock_i      (clock_i),
  .rst_i        (rst_i),
  .sel_n_i      (sel_n_i),
  .wp_n_i       (wp_n_i),
  .sdo_oe_o     (sdo_oe_o),
  .array_wr_o   (array_wr_o),
  .array_addr_o (array_addr_o),
  .status_o     (status_o),
  .hw_protect_o (hw_protect_o)
);

// *** test/sewp_host.sv ***
// Purpose: SPI host model for sewp_core
// Assumes: Mode 0, sck period 16 clocks
// Notes:   Select starts low, as if low at power-up
`timescale 1ns/100ps
module sewp_host (
  input  logic clock_i,
  input  logic sdo_i,
  output logic sel_n_o,
  output logic sck_o,
  output logic sdi_o
);
  logic [31:0] rx = 32'h0000_0000;
  initial begin
    sel_n_o = 1'b0;
    sck_o = 1'b0;
    sdi_o = 1'b0;
  end
  // Sends n bits of d, then deselects
  task automatic frame(input logic [31:0] d, input int n);
    repeat (4) @(posedge clock_i);
    sel_n_o <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sck_o <= 1'b0;
      sdi_o <= d[i];
      repeat (8) @(posedge clock_i);
      sck_o <= 1'b1;
      rx = {rx[30:0], sdo_i};
      repeat (8) @(posedge clock_i);
    end
    sck_o <= 1'b0;
    repeat (8) @(posedge clock_i);
    sel_n_o <= 1'b1;
    sdi_o <= ~sdi_o;
    repeat (12) @(posedge clock_i);
  endtask
endmodule

// *** test/sewp_core_tb_top.sv ***
// Purpose: Self-checking bench for sewp_core
// Assumes: WRITE_CYCLES shortened to 1000
// Notes:   Host model drives the link pins
`timescale 1ns/100ps
module sewp_core_tb_top;
  logic        clock_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wp_n_i = 1'b1;
  localparam int WR_CYC = 1000;
  logic        sel_n, sck, sdi, sdo, oe, wr, hwp, lk;
  wire         sdo_line = oe ? sdo : ~sdo;
  int          busy_cyc = 0;
  logic [12:0] addr, wa;
  logic [7:0]  wd, d, st;
  logic [12:0] ad [3] = '{13'h0000, 13'h1000, 13'h1800};
  int          err_count = 0;
  int          tests_run = 0;
  int          n_wr = 0;
  int          n_exp = 0;
  always #5 clock_i = ~clock_i;
  sewp_host host (.clock_i(clock_i), .sdo_i(sdo_line), .sel_n_o(sel_n), .sck_o(sck),
    .sdi_o(sdi));
  sewp_core #(.WRITE_CYCLES(WR_CYC)) dut (.clock_i(clock_i), .rst_i(rst_i),
    .sel_n_i(sel_n), .sck_i(sck), .sdi_i(sdi), .wp_n_i(wp_n_i), .sdo_o(sdo),
    .sdo_oe_o(oe), .array_wr_o(wr), .array_addr_o(addr), .array_data_o(wd),
    .status_o(st), .hw_protect_o(hwp));
  always @(posedge clock_i) if (wr === 1'b1) begin
    n_wr++;
    wa = addr;
    d = wd;
  end
  always @(posedge clock_i) if (st[0] === 1'b1) busy_cyc++;
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Waits until the write cycle, if any, has ended
  task automatic idle;
    repeat (4) @(posedge clock_i);
    for (int n = 0; n < 2 * WR_CYC && st[0] !== 1'b0; n++) @(posedge clock_i);
  endtask
  task automatic sw(input logic [7:0] v);
    host.frame(8'h06, 8);
    host.frame({8'h01, v}, 16);
    idle;
  endtask
  task automatic aw(input logic [12:0] a, input logic [7:0] v);
    host.frame(8'h06, 8);
    host.frame({8'h02, 3'h0, a, v}, 32);
    idle;
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    chk(st, 8'h00);
    chk(oe, 1'b0);
    host.frame(8'h06, 8);
    chk(st, 8'h00);
    host.frame(8'h06, 8);
    chk(st, 8'h02);
    host.frame(8'h04, 8);
    chk(st, 8'h00);
    host.frame({8'h01, 8'h8c}, 16);
    chk(st, 8'h00);
    for (int c = 0; c < 4; c++) begin
      sw({4'h0, c[1:0], 2'b00});
      chk(st, {4'h0, c[1:0], 2'b00});
      for (int k = 0; k < 3; k++) begin
        lk = (c == 3) || (c == 2 && k > 0) || (c == 1 && k == 2);
        aw(ad[k], 8'h5a);
        n_exp += !lk;
        chk(13'(n_wr), 13'(n_exp));
        chk(st, {4'h0, c[1:0], lk, 1'b0});
        if (!lk) chk(wa, ad[k]);
      end
    end
    sw(8'h84);
    chk(st, 8'h84);
    wp_n_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    chk(hwp, 1'b1);
    sw(8'h00);
    chk(st, 8'h86);
    host.frame({8'h05, 8'h00}, 16);
    chk(host.rx[7:0], 8'h86);
    aw(13'h0000, 8'h3c);
    chk(13'(n_wr), 13'(n_exp + 1));
    chk(d, 8'h3c);
    wp_n_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    chk(hwp, 1'b0);
    host.frame(8'h06, 8);
    host.frame({8'h01, 8'h0c, 1'b0}, 17);
    chk(st, 8'h86);
    sw(8'h00);
    chk(st, 8'h00);
    busy_cyc = 0;
    host.frame(8'h06, 8);
    host.frame({8'h02, 16'h0020, 8'h11}, 32);
    host.frame(8'h06, 8);
    host.frame({8'h02, 16'h0021, 8'h22}, 32);
    idle;
    chk(13'(n_wr), 13'(n_exp + 2));
    chk(wa, 13'h0020);
    chk(d, 8'h11);
    chk(st, 8'h02);
    chk(13'(busy_cyc), 13'(WR_CYC + 1));
    end_of_test;
  end
  initial begin
    repeat (60000) @(posedge clock_i);
    err_count++;
    end_of_test;
  end
endmodule
